// file: rtl/sbx_exec.sv
// execute stage for shifts, bit-field ops, bit clear, branches and misc ops
// assumes decoder supplies operands and a pre-evaluated condition each cycle
// Contract
// - arithmetic shift fills vacated bits with sign
// - shift amounts one to thirty-two accepted
// - register shift amount uses lowest byte only
// - flags update only when set-flags requested
// - compact wide plain branch is PC-relative 32-bit
// - field clear zeros width bits from lsb
// - field insert copies source low bits at lsb
// - bit clear ANDs first with complemented second
// - breakpoint enters debug, immediate ignored
// - linked branch jumps, writes return address R14
// - linked exchange immediate branch toggles state
// - register exchange picks state from bit0
// - bytecode branch falls back to register exchange
// - zero-test branches, flags untouched, 16-bit only
// - coprocessor op routed with opcodes and registers
// - bound check faults when size not above index
// - exclusive clear reopens the local monitor
`timescale 1ns/1ps
module sbx_exec
  import sbx_pkg::*;
#(
  parameter int DATA_W = WORD_W // must stay 32
) (
  input wire logic clock, // core clock
  input wire logic rst, // synchronous reset, high
  input wire logic opValid, // operation presented this cycle
  input wire sbx_op_t opCode, // which operation
  input wire logic condPass, // condition code evaluated true
  input wire logic setFlags, // flag-setting suffix present
  input wire logic narrowEnc, // encoded as 16-bit
  input wire logic wideQual, // width qualifier on plain branch
  input wire logic extCompact, // extended compact state active
  input wire logic [DATA_W-1:0] firstOperand, // first operand register value
  input wire logic [DATA_W-1:0] sourceOperand, // source operand register value
  input wire logic [DATA_W-1:0] flexOperand, // flexible operand value
  input wire logic [DATA_W-1:0] destOld, // destination current value
  input wire logic [DATA_W-1:0] shiftAmtReg, // shift amount register value
  input wire logic [SHIFT_IMM_W-1:0] shiftImm, // immediate shift amount
  input wire logic shiftByImm, // use immediate shift amount
  input wire logic [4:0] fieldLsb, // field lowest bit
  input wire logic [5:0] fieldWidth, // field width
  input wire logic [DATA_W-1:0] pc, // address of this operation
  input wire logic [DATA_W-1:0] branchOffset, // signed PC-relative offset
  input wire logic [3:0] flagsIn, // current status flags
  input wire logic bytecodeEntryOk, // bytecode state entry possible
  input wire logic exclReserve, // exclusive load marks a reservation
  input wire logic [3:0] cpNumIn, // coprocessor number
  input wire logic [3:0] cpPrimaryIn, // coprocessor primary code
  input wire logic [2:0] cpSecondaryIn, // coprocessor secondary code
  input wire logic [3:0] cpRdIn, // coprocessor destination register
  input wire logic [3:0] cpRnIn, // coprocessor first register
  input wire logic [3:0] cpRmIn, // coprocessor second register
  output logic doneValid_r, // one-cycle result strobe
  output logic rdWrite_r, // write destination register
  output logic [DATA_W-1:0] rdData_r, // destination data
  output logic linkWrite_r, // write link register
  output logic [3:0] linkIdx_r, // link register number
  output logic [DATA_W-1:0] linkData_r, // return address
  output logic flagWrite_r, // write status flags
  output logic [3:0] flagsOut_r, // new status flags
  output logic branchTaken_r, // redirect fetch
  output logic [DATA_W-1:0] branchTarget_r, // redirect address
  output sbx_isa_t isaState_r, // current instruction state
  output logic debugHalt_r, // enter debug state pulse
  output logic indexFault_r, // call index fault handler pulse
  output logic monitorOpen_r, // exclusive monitor open
  output logic cpValid_r, // coprocessor dispatch pulse
  output logic [3:0] cpNum_r, // coprocessor number
  output logic [3:0] cpPrimary_r, // primary code
  output logic [2:0] cpSecondary_r, // secondary code
  output logic [3:0] cpRd_r, // coprocessor registers
  output logic [3:0] cpRn_r,
  output logic [3:0] cpRm_r,
  output logic illegalOp_r // encoding not allowed in this state
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration check
  if (DATA_W != 32) begin : g_bad_width
    $error("sbx_exec supports only a 32-bit datapath");
  end

  ////////////////////////////////////////////////////////////////////////////
  // datapath helpers
  logic [8:0] shAmt; // effective shift amount
  logic [DATA_W-1:0] asrRes; // shifted result
  logic asrCarry; // last bit shifted out
  logic [DATA_W-1:0] fieldMask; // ones over the field
  logic fieldBad; // field empty or runs past bit 31
  logic [DATA_W-1:0] bicRes; // bit clear result
  logic [DATA_W-1:0] relTarget; // PC-relative target
  logic [DATA_W-1:0] nextPc; // following instruction address
  logic [4:0] carryIdx; // position of last bit out

  // shift amount, field mask and targets
  always_comb begin
    if (shiftByImm) begin
      shAmt = (shiftImm == '0) ? SHIFT_MAX : {3'h0, shiftImm};
    end else begin
      shAmt = {1'b0, shiftAmtReg[SHIFT_BYTE_W-1:0]};
    end
    carryIdx = 5'(shAmt - 9'h001);
    if (shAmt >= SHIFT_MAX) begin
      asrRes = {DATA_W{sourceOperand[DATA_W-1]}};
      asrCarry = sourceOperand[DATA_W-1];
    end else begin
      asrRes = DATA_W'($signed(sourceOperand) >>> shAmt[4:0]);
      asrCarry = (shAmt == '0) ? flagsIn[FLAG_C] : sourceOperand[carryIdx];
    end
    fieldBad = (fieldWidth == '0) || ({1'b0, fieldLsb} + fieldWidth > 6'(DATA_W));
    if (fieldWidth >= 6'(DATA_W)) begin
      fieldMask = {DATA_W{1'b1}};
    end else begin
      fieldMask = ((DATA_W'(1) << fieldWidth) - DATA_W'(1)) << fieldLsb;
    end
    bicRes = firstOperand & ~flexOperand;
    relTarget = pc + branchOffset;
    nextPc = pc + (narrowEnc ? INSN_BYTES_NARROW : INSN_BYTES_WIDE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // next-state computation
  logic doneValid_nxt, rdWrite_nxt, linkWrite_nxt, flagWrite_nxt, branchTaken_nxt;
  logic [DATA_W-1:0] rdData_nxt, linkData_nxt, branchTarget_nxt;
  logic [3:0] flagsOut_nxt;
  sbx_isa_t isaState_nxt;
  logic debugHalt_nxt, indexFault_nxt, monitorOpen_nxt, cpValid_nxt, illegalOp_nxt;
  logic exec; // operation passes its condition
  logic [DATA_W-1:0] logicRes; // result for flag setting

  always_comb begin
    exec = opValid && condPass;
    logicRes = '0;
    doneValid_nxt = opValid;
    rdWrite_nxt = 1'b0;
    rdData_nxt = rdData_r;
    linkWrite_nxt = 1'b0;
    linkData_nxt = linkData_r;
    flagWrite_nxt = 1'b0;
    flagsOut_nxt = flagsIn;
    branchTaken_nxt = 1'b0;
    branchTarget_nxt = branchTarget_r;
    isaState_nxt = isaState_r;
    debugHalt_nxt = 1'b0;
    indexFault_nxt = 1'b0;
    cpValid_nxt = 1'b0;
    illegalOp_nxt = 1'b0;
    // a new reservation wins over a clear in the same cycle
    monitorOpen_nxt = exclReserve ? 1'b0 : monitorOpen_r;
    if (exec) begin
      unique case (opCode)
        SBX_OP_ASR, SBX_OP_AND_COMPL: begin
          logicRes = (opCode == SBX_OP_ASR) ? asrRes : bicRes;
          rdWrite_nxt = 1'b1;
          rdData_nxt = logicRes;
          flagWrite_nxt = setFlags;
          flagsOut_nxt[FLAG_N] = logicRes[DATA_W-1];
          flagsOut_nxt[FLAG_Z] = (logicRes == '0);
          if (opCode == SBX_OP_ASR) begin
            flagsOut_nxt[FLAG_C] = asrCarry;
          end
        end
        SBX_OP_FIELD_CLEAR, SBX_OP_FIELD_INSERT: begin
          illegalOp_nxt = fieldBad;
          rdWrite_nxt = !fieldBad;
          if (opCode == SBX_OP_FIELD_CLEAR) begin
            rdData_nxt = destOld & ~fieldMask;
          end else begin
            rdData_nxt = (destOld & ~fieldMask) | ((firstOperand << fieldLsb) & fieldMask);
          end
        end
        SBX_OP_BRANCH: begin
          // in compact state the qualified form is a 32-bit encoding
          illegalOp_nxt = (isaState_r == SBX_ISA_COMPACT) && wideQual && narrowEnc;
          branchTaken_nxt = !illegalOp_nxt;
          branchTarget_nxt = relTarget;
        end
        SBX_OP_CALL, SBX_OP_CALL_EXCH_IMM: begin
          branchTaken_nxt = 1'b1;
          branchTarget_nxt = relTarget;
          linkWrite_nxt = 1'b1;
          linkData_nxt = nextPc;
          if (opCode == SBX_OP_CALL_EXCH_IMM) begin
            isaState_nxt = (isaState_r == SBX_ISA_WIDE) ? SBX_ISA_COMPACT : SBX_ISA_WIDE;
          end
        end
        SBX_OP_CALL_EXCH_REG, SBX_OP_BRANCH_EXCH, SBX_OP_BYTECODE_BRANCH: begin
          branchTaken_nxt = 1'b1;
          branchTarget_nxt = {sourceOperand[DATA_W-1:1], 1'b0};
          isaState_nxt = sourceOperand[0] ? SBX_ISA_COMPACT : SBX_ISA_WIDE;
          if (opCode == SBX_OP_BYTECODE_BRANCH && bytecodeEntryOk) begin
            isaState_nxt = SBX_ISA_BYTECODE;
          end
          if (opCode == SBX_OP_CALL_EXCH_REG) begin
            linkWrite_nxt = 1'b1;
            linkData_nxt = nextPc;
          end
        end
        SBX_OP_ZERO_TEST, SBX_OP_NONZERO_TEST: begin
          // flags never written; only 16-bit compact forms exist
          illegalOp_nxt = !narrowEnc || (isaState_r != SBX_ISA_COMPACT);
          branchTaken_nxt = !illegalOp_nxt &&
            ((firstOperand == '0) == (opCode == SBX_OP_ZERO_TEST));
          branchTarget_nxt = relTarget;
        end
        SBX_OP_DEBUG_HALT: begin
          debugHalt_nxt = 1'b1;
        end
        SBX_OP_COPROC: begin
          cpValid_nxt = 1'b1;
        end
        SBX_OP_ARRAY_CHECK: begin
          illegalOp_nxt = !narrowEnc || !extCompact || (isaState_r != SBX_ISA_COMPACT);
          indexFault_nxt = !illegalOp_nxt && (firstOperand <= sourceOperand);
        end
        SBX_OP_MONITOR_CLEAR: begin
          monitorOpen_nxt = !exclReserve;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clock) begin
    if (rst) begin
      doneValid_r <= 1'b0;
      rdWrite_r <= 1'b0;
      rdData_r <= '0;
      linkWrite_r <= 1'b0;
      linkData_r <= '0;
      flagWrite_r <= 1'b0;
      flagsOut_r <= '0;
      branchTaken_r <= 1'b0;
      branchTarget_r <= '0;
      isaState_r <= ISA_RESET;
      debugHalt_r <= 1'b0;
      indexFault_r <= 1'b0;
      monitorOpen_r <= MONITOR_OPEN_RESET;
      cpValid_r <= 1'b0;
      cpNum_r <= '0;
      cpPrimary_r <= '0;
      cpSecondary_r <= '0;
      cpRd_r <= '0;
      cpRn_r <= '0;
      cpRm_r <= '0;
      illegalOp_r <= 1'b0;
    end else begin
      doneValid_r <= doneValid_nxt;
      rdWrite_r <= rdWrite_nxt;
      rdData_r <= rdData_nxt;
      linkWrite_r <= linkWrite_nxt;
      linkData_r <= linkData_nxt;
      flagWrite_r <= flagWrite_nxt;
      flagsOut_r <= flagsOut_nxt;
      branchTaken_r <= branchTaken_nxt;
      branchTarget_r <= branchTarget_nxt;
      isaState_r <= isaState_nxt;
      debugHalt_r <= debugHalt_nxt;
      indexFault_r <= indexFault_nxt;
      monitorOpen_r <= monitorOpen_nxt;
      cpValid_r <= cpValid_nxt;
      cpNum_r <= cpNumIn;
      cpPrimary_r <= cpPrimaryIn;
      cpSecondary_r <= cpSecondaryIn;
      cpRd_r <= cpRdIn;
      cpRn_r <= cpRnIn;
      cpRm_r <= cpRmIn;
      illegalOp_r <= illegalOp_nxt;
    end
  end

  assign linkIdx_r = LINK_REG_IDX;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  a_asr_sign_fill: assert property (@(posedge clock) disable iff (rst)
    exec && opCode == SBX_OP_ASR && !shiftByImm && shiftAmtReg[7:0] >= 8'h20
    |=> rdData_r == {DATA_W{$past(sourceOperand[DATA_W-1])}})
    else $error("shift did not fill with sign");
  a_asr_imm_amount: assert property (@(posedge clock) disable iff (rst)
    exec && opCode == SBX_OP_ASR && shiftByImm && shiftImm == 6'h01
    |=> rdData_r == {$past(sourceOperand[DATA_W-1]), $past(sourceOperand[DATA_W-1:1])})
    else $error("immediate shift by one wrong");
  a_shift_low_byte: assert property (@(posedge clock) disable iff (rst)
    exec && opCode == SBX_OP_ASR && !shiftByImm && shiftAmtReg[7:0] == 8'h00
    |=> rdData_r == $past(sourceOperand))
    else $error("upper shift bits not ignored");
  a_flags_gated: assert property (@(posedge clock) disable iff (rst)
    opValid |=> flagWrite_r == $past(exec && setFlags &&
      (opCode == SBX_OP_ASR || opCode == SBX_OP_AND_COMPL)))
    else $error("flag write not gated by suffix");
  a_field_clear: assert property (@(posedge clock) disable iff (rst)
    exec && opCode == SBX_OP_FIELD_CLEAR && !fieldBad
    |=> rdWrite_r && (rdData_r & $past(fieldMask)) == '0 &&
      (rdData_r | $past(fieldMask)) == ($past(destOld) | $past(fieldMask)))
    else $error("field clear touched wrong bits");
  a_field_insert: assert property (@(posedge clock) disable iff (rst)
    exec && opCode == SBX_OP_FIELD_INSERT && fieldLsb == 5'h00 && fieldWidth == 6'h20
    |=> rdData_r == $past(firstOperand))
    else $error("full field insert wrong");
  a_bit_clear: assert property (@(posedge clock) disable iff (rst)
    exec && opCode == SBX_OP_AND_COMPL
    |=> rdData_r == ($past(firstOperand) & ~$past(flexOperand)))
    else $error("bit clear result wrong");
  a_debug_halt: assert property (@(posedge clock) disable iff (rst)
    debugHalt_r |-> $past(exec) && $past(opCode) == SBX_OP_DEBUG_HALT)
    else $error("debug entry without breakpoint");
  a_call_link: assert property (@(posedge clock) disable iff (rst)
    exec && opCode == SBX_OP_CALL
    |=> branchTaken_r && linkWrite_r && branchTarget_r == $past(pc) + $past(branchOffset))
    else $error("call did not link and jump");
  a_call_toggle: assert property (@(posedge clock) disable iff (rst)
    exec && opCode == SBX_OP_CALL_EXCH_IMM && isaState_r == SBX_ISA_WIDE
    |=> isaState_r == SBX_ISA_COMPACT)
    else $error("call exchange did not toggle state");
  a_exch_bit0: assert property (@(posedge clock) disable iff (rst)
    exec && opCode == SBX_OP_BRANCH_EXCH
    |=> isaState_r == ($past(sourceOperand[0]) ? SBX_ISA_COMPACT : SBX_ISA_WIDE))
    else $error("exchange state not from bit0");
  a_bytecode_fallback: assert property (@(posedge clock) disable iff (rst)
    exec && opCode == SBX_OP_BYTECODE_BRANCH && !bytecodeEntryOk
    |=> isaState_r != SBX_ISA_BYTECODE && branchTaken_r)
    else $error("failed bytecode entry not a plain exchange");
  a_zero_test: assert property (@(posedge clock) disable iff (rst)
    exec && (opCode == SBX_OP_ZERO_TEST || opCode == SBX_OP_NONZERO_TEST)
    |=> !flagWrite_r && (branchTaken_r -> $past(narrowEnc)))
    else $error("zero test branch misbehaved");
  a_coproc_route: assert property (@(posedge clock) disable iff (rst)
    cpValid_r |-> cpNum_r == $past(cpNumIn) && cpPrimary_r == $past(cpPrimaryIn))
    else $error("coprocessor fields not routed");
  a_bound_fault: assert property (@(posedge clock) disable iff (rst)
    exec && opCode == SBX_OP_ARRAY_CHECK && narrowEnc && extCompact &&
    isaState_r == SBX_ISA_COMPACT
    |=> indexFault_r == $past(firstOperand <= sourceOperand))
    else $error("bound check fault wrong");
  a_monitor_clear: assert property (@(posedge clock) disable iff (rst)
    exec && opCode == SBX_OP_MONITOR_CLEAR && !exclReserve |=> monitorOpen_r)
    else $error("monitor not reopened");
  a_cond_suppress: assert property (@(posedge clock) disable iff (rst)
    opValid && !condPass |=> !rdWrite_r && !linkWrite_r && !flagWrite_r &&
      !branchTaken_r && $stable(isaState_r) && !debugHalt_r && !cpValid_r)
    else $error("failed condition had an effect");

  c_call_exch: cover property (@(posedge clock) disable iff (rst)
    exec && opCode == SBX_OP_CALL_EXCH_IMM ##1 exec && opCode == SBX_OP_BRANCH_EXCH);
  c_asr_flags: cover property (@(posedge clock) disable iff (rst)
    exec && opCode == SBX_OP_ASR && setFlags);
  c_index_fault: cover property (@(posedge clock) disable iff (rst) indexFault_r);
  c_bytecode: cover property (@(posedge clock) disable iff (rst)
    isaState_r == SBX_ISA_BYTECODE);
endmodule : sbx_exec

// file: rtl/sbx_pkg.sv
// shared constants and types for the shift, bit-field and branch execute block
// assumes one core clock domain and a decoder that presents one operation per cycle
package sbx_pkg;
  localparam int WORD_W = 32; // datapath width the logic is written for
  localparam int SHIFT_BYTE_W = 8; // low bits of a shift register that count
  localparam int SHIFT_IMM_W = 6; // immediate shift field
  localparam logic [8:0] SHIFT_MAX = 9'h020; // largest documented shift amount
  localparam logic [31:0] INSN_BYTES_WIDE = 32'h0000_0004; // wide or 32-bit encoding
  localparam logic [31:0] INSN_BYTES_NARROW = 32'h0000_0002; // 16-bit encoding
  localparam logic [3:0] LINK_REG_IDX = 4'hE; // link register number
  localparam int FLAG_N = 3; // negative flag position
  localparam int FLAG_Z = 2; // zero flag position
  localparam int FLAG_C = 1; // carry flag position
  localparam int FLAG_V = 0; // overflow flag position
  localparam logic MONITOR_OPEN_RESET = 1'b1; // monitor open after reset

  // operations this block executes
  typedef enum logic [3:0] {
    SBX_OP_ASR, SBX_OP_FIELD_CLEAR, SBX_OP_FIELD_INSERT, SBX_OP_AND_COMPL,
    SBX_OP_BRANCH, SBX_OP_CALL, SBX_OP_CALL_EXCH_IMM, SBX_OP_CALL_EXCH_REG,
    SBX_OP_BRANCH_EXCH, SBX_OP_BYTECODE_BRANCH, SBX_OP_ZERO_TEST, SBX_OP_NONZERO_TEST,
    SBX_OP_DEBUG_HALT, SBX_OP_COPROC, SBX_OP_ARRAY_CHECK, SBX_OP_MONITOR_CLEAR
  } sbx_op_t;

  // instruction states of the core
  typedef enum logic [1:0] {SBX_ISA_WIDE, SBX_ISA_COMPACT, SBX_ISA_BYTECODE} sbx_isa_t;
  localparam sbx_isa_t ISA_RESET = SBX_ISA_WIDE; // state after reset
endpackage : sbx_pkg

// file: test/sbx_coproc_model.sv
// coprocessor stand-in that latches each dispatched data operation
// assumes dispatch fields are valid only in the cycle of the strobe
`timescale 1ns/1ps
module sbx_coproc_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic cpValid,
  input wire logic [3:0] cpNum,
  input wire logic [3:0] cpPrimary,
  input wire logic [2:0] cpSecondary,
  input wire logic [3:0] cpRd,
  input wire logic [3:0] cpRn,
  input wire logic [3:0] cpRm,
  output logic [22:0] lastCmd_r,
  output logic [7:0] cmdCount_r
);
  ////////////////////////////////////////
  // take a command only with its strobe, count every one
  always_ff @(posedge clock) begin
    if (rst) begin
      lastCmd_r <= 23'h000000;
      cmdCount_r <= 8'h00;
    end else if (cpValid) begin
      lastCmd_r <= {cpNum, cpPrimary, cpSecondary, cpRd, cpRn, cpRm};
      cmdCount_r <= cmdCount_r + 8'h01;
    end
  end
endmodule : sbx_coproc_model

// file: test/shift_bitfield_branch_exec_tb.sv
// self-checking bench for the shift, bit-field and branch execute stage
// assumes one clock, synchronous reset, results one cycle after each op
`timescale 1ns/1ps
module shift_bitfield_branch_exec_tb import sbx_pkg::*;;
  // expected outcome of one op
  typedef struct packed {
    logic rw;
    logic [31:0] rd;
    logic lw;
    logic [31:0] ld;
    logic fw;
    logic [3:0] fl;
    logic bt;
    logic xb;
    logic [31:0] tg;
    sbx_isa_t isa;
    logic [4:0] ev;
  } sbx_exp_t;
  localparam logic [31:0] PC0 = 32'h0000_1000;
  localparam logic [31:0] TGT = 32'h0000_1040;
  logic clock, rst, opValid, condPass, setFlags, narrowEnc, wideQual, extCompact;
  logic shiftByImm, bytecodeEntryOk, exclReserve;
  sbx_op_t opCode;
  logic [31:0] firstOperand, sourceOperand, flexOperand, destOld, shiftAmtReg, pc, branchOffset;
  logic [5:0] shiftImm, fieldWidth;
  logic [4:0] fieldLsb;
  logic [3:0] flagsIn, cpNumIn, cpPrimaryIn, cpRdIn, cpRnIn, cpRmIn;
  logic [2:0] cpSecondaryIn, cpSecondary_r;
  logic doneValid_r, rdWrite_r, linkWrite_r, flagWrite_r, branchTaken_r, debugHalt_r;
  logic indexFault_r, monitorOpen_r, cpValid_r, illegalOp_r;
  logic [31:0] rdData_r, linkData_r, branchTarget_r;
  logic [3:0] linkIdx_r, flagsOut_r, cpNum_r, cpPrimary_r, cpRd_r, cpRn_r, cpRm_r;
  sbx_isa_t isaState_r, isaM;
  logic [22:0] lastCmd_r;
  logic [7:0] cmdCount_r;
  int fails, n_compared;
  sbx_exp_t expQ[$];
  sbx_exp_t cur;
  logic monM;
  sbx_exec dut (
    .clock, .rst, .opValid, .opCode, .condPass, .setFlags, .narrowEnc, .wideQual,
    .extCompact, .firstOperand, .sourceOperand, .flexOperand, .destOld, .shiftAmtReg,
    .shiftImm, .shiftByImm, .fieldLsb, .fieldWidth, .pc, .branchOffset, .flagsIn,
    .bytecodeEntryOk, .exclReserve, .cpNumIn, .cpPrimaryIn, .cpSecondaryIn, .cpRdIn,
    .cpRnIn, .cpRmIn, .doneValid_r, .rdWrite_r, .rdData_r, .linkWrite_r, .linkIdx_r,
    .linkData_r, .flagWrite_r, .flagsOut_r, .branchTaken_r, .branchTarget_r, .isaState_r,
    .debugHalt_r, .indexFault_r, .monitorOpen_r, .cpValid_r, .cpNum_r, .cpPrimary_r,
    .cpSecondary_r, .cpRd_r, .cpRn_r, .cpRm_r, .illegalOp_r
  );
  sbx_coproc_model cpm (
    .clock, .rst, .cpValid(cpValid_r), .cpNum(cpNum_r), .cpPrimary(cpPrimary_r),
    .cpSecondary(cpSecondary_r), .cpRd(cpRd_r), .cpRn(cpRn_r), .cpRm(cpRm_r),
    .lastCmd_r, .cmdCount_r
  );
  ////////////////////////////////////////
  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  // nothing-happens outcome in the current state
  function automatic sbx_exp_t base();
    sbx_exp_t e;
    e = '0;
    e.isa = isaM;
    e.ev = {4'h0, monM};
    return e;
  endfunction : base
  // ctl is {condPass, narrowEnc, wideQual, extCompact, setFlags}
  task automatic go(input sbx_op_t c, input logic [4:0] ctl, input sbx_exp_t e);
    opCode <= c;
    {condPass, narrowEnc, wideQual, extCompact, setFlags} <= ctl;
    opValid <= 1'b1;
    expQ.push_back(e);
    @(posedge clock);
  endtask : go
  task automatic idle(input string name);
    opValid <= 1'b0;
    repeat (3) @(posedge clock);
    $display("test %s done", name);
  endtask : idle
  // register exchange branch, state from target bit 0
  task automatic exch(input sbx_op_t c, input logic [31:0] r, input logic lk);
    sbx_exp_t e;
    isaM = r[0] ? SBX_ISA_COMPACT : SBX_ISA_WIDE;
    e = base();
    e.bt = 1'b1;
    e.tg = r & 32'hFFFF_FFFE;
    e.lw = lk;
    e.ld = PC0 + INSN_BYTES_WIDE;
    sourceOperand <= r;
    firstOperand <= r;
    go(c, 5'h10, e);
  endtask : exch
  ////////////////////////////////////////
  // score each finished op against the oldest note
  always @(posedge clock) begin
    if (doneValid_r === 1'b1) begin
      cur = expQ.pop_front();
      check(rdWrite_r, cur.rw);
      if (cur.rw) check(rdData_r, cur.rd);
      check(flagWrite_r, cur.fw);
      if (cur.fw) check(flagsOut_r, cur.fl);
      check(linkWrite_r, cur.lw);
      if (cur.lw) check({linkIdx_r, linkData_r}, {LINK_REG_IDX, cur.ld});
      if (!cur.xb) check(branchTaken_r, cur.bt);
      if (cur.bt && !cur.xb) check(branchTarget_r, cur.tg);
      check(isaState_r, cur.isa);
      check({debugHalt_r, indexFault_r, cpValid_r, illegalOp_r, monitorOpen_r},
        cur.ev);
    end
  end
  initial begin
    #20000;
    fails++;
    close_out();
  end
  initial begin
    logic [31:0] s, d, v, m, cpv;
    logic [32:0] w;
    logic [3:0] fi;
    logic sf, bi;
    int a, lo, wd;
    sbx_exp_t e;
    sbx_op_t c;
    {opValid, condPass, setFlags, narrowEnc, wideQual, extCompact, shiftByImm} = '0;
    {bytecodeEntryOk, exclReserve, firstOperand, sourceOperand, flexOperand, destOld} = '0;
    {shiftAmtReg, pc, branchOffset, shiftImm, fieldWidth, fieldLsb, flagsIn} = '0;
    {cpNumIn, cpPrimaryIn, cpSecondaryIn, cpRdIn, cpRnIn, cpRmIn} = '0;
    opCode = SBX_OP_ASR;
    rst = 1'b1;
    isaM = ISA_RESET;
    monM = MONITOR_OPEN_RESET;
    void'($urandom(21065));
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    check({isaState_r, monitorOpen_r, doneValid_r}, {ISA_RESET, MONITOR_OPEN_RESET, 1'b0});
    for (int k = 0; k < 24; k++) begin
      s = $urandom; fi = 4'($urandom); sf = 1'($urandom);
      bi = k == 2 || (k > 2 && 1'($urandom));
      // fixed picks first: register byte zero, register forty, immediate one
      a = k < 2 ? 40 * k : k == 2 ? 1 : bi ? 1 + $urandom % 32 : $urandom % 41;
      w = $signed({s, 1'b0}) >>> a;
      e = base(); e.rw = 1'b1; e.rd = w[32:1]; e.fw = sf;
      e.fl = {w[32], w[32:1] == 32'h0, a == 0 ? fi[1] : w[0], fi[0]};
      sourceOperand <= s; flagsIn <= fi; shiftByImm <= bi;
      shiftImm <= 6'(a % 32);
      shiftAmtReg <= {24'($urandom), 8'(a)};
      go(SBX_OP_ASR, {4'h8, sf}, e);
    end
    idle("shift");
    for (int k = 0; k < 17; k++) begin
      lo = k == 16 ? 20 : k < 2 ? 0 : $urandom % 32;
      wd = k == 16 ? 13 : k < 2 ? 32 : 1 + $urandom % (32 - lo);
      m = 32'((64'h1 << wd) - 1) << lo;
      s = $urandom; d = $urandom;
      e = base(); e.rw = k < 16; e.ev[1] = k == 16;
      e.rd = k[0] ? (d & ~m) | ((s << lo) & m) : d & ~m;
      destOld <= d; sourceOperand <= s; firstOperand <= s;
      fieldLsb <= 5'(lo); fieldWidth <= 6'(wd);
      go(k[0] ? SBX_OP_FIELD_INSERT : SBX_OP_FIELD_CLEAR, 5'h10, e);
    end
    repeat (8) begin
      s = $urandom; v = $urandom; fi = 4'($urandom); sf = 1'($urandom);
      e = base(); e.rw = 1'b1; e.rd = s & ~v; e.fw = sf;
      e.fl = {e.rd[31], e.rd == 32'h0, fi[1:0]};
      firstOperand <= s; flexOperand <= v; flagsIn <= fi;
      go(SBX_OP_AND_COMPL, {4'h8, sf}, e);
    end
    idle("bitfield");
    pc <= PC0; branchOffset <= TGT - PC0;
    e = base(); e.bt = 1'b1; e.tg = TGT;
    go(SBX_OP_BRANCH, 5'h10, e);
    e.lw = 1'b1; e.ld = PC0 + INSN_BYTES_WIDE;
    go(SBX_OP_CALL, 5'h10, e);
    isaM = SBX_ISA_COMPACT; e.isa = isaM;
    go(SBX_OP_CALL_EXCH_IMM, 5'h10, e);
    e.ld = PC0 + INSN_BYTES_NARROW;
    go(SBX_OP_CALL, 5'h18, e);
    e.lw = 1'b0;
    go(SBX_OP_BRANCH, 5'h14, e);
    e = base(); e.ev[1] = 1'b1;
    go(SBX_OP_BRANCH, 5'h1C, e);
    go(SBX_OP_ZERO_TEST, 5'h11, e);
    for (int k = 0; k < 4; k++) begin
      v = k[0] ? $urandom | 32'h1 : 32'h0;
      e = base(); e.bt = k[1] ? v != 0 : v == 0; e.tg = TGT;
      firstOperand <= v; sourceOperand <= v; flagsIn <= 4'($urandom);
      go(k[1] ? SBX_OP_NONZERO_TEST : SBX_OP_ZERO_TEST, 5'h19, e);
    end
    for (int k = 0; k < 4; k++) begin
      e = base(); e.ev[3] = k == 1 || k == 2; e.ev[1] = k == 3;
      firstOperand <= 32'h0000_0010; sourceOperand <= 32'(15 + k);
      go(SBX_OP_ARRAY_CHECK, k == 3 ? 5'h18 : 5'h1A, e);
    end
    isaM = SBX_ISA_WIDE;
    e = base(); e.bt = 1'b1; e.tg = TGT; e.lw = 1'b1; e.ld = PC0 + INSN_BYTES_WIDE;
    go(SBX_OP_CALL_EXCH_IMM, 5'h10, e);
    exch(SBX_OP_BRANCH_EXCH, 32'h0000_2001, 1'b0);
    exch(SBX_OP_BRANCH_EXCH, 32'h0000_3000, 1'b0);
    exch(SBX_OP_CALL_EXCH_REG, 32'h0000_4001, 1'b1);
    exch(SBX_OP_BYTECODE_BRANCH, 32'h0000_5000, 1'b0);
    e = base(); e.ev[1] = 1'b1;
    go(SBX_OP_ZERO_TEST, 5'h19, e);
    idle("branch");
    cpv = $urandom;
    {cpNumIn, cpPrimaryIn, cpSecondaryIn, cpRdIn, cpRnIn, cpRmIn} <= cpv[22:0];
    e = base(); e.ev[2] = 1'b1;
    go(SBX_OP_COPROC, 5'h10, e);
    exclReserve <= 1'b1; monM = 1'b0;
    e = base(); e.ev[4] = 1'b1;
    go(SBX_OP_DEBUG_HALT, 5'h10, e);
    exclReserve <= 1'b0; monM = 1'b1;
    go(SBX_OP_MONITOR_CLEAR, 5'h10, base());
    exclReserve <= 1'b1; monM = 1'b0;
    go(SBX_OP_MONITOR_CLEAR, 5'h10, base());
    exclReserve <= 1'b0; fieldLsb <= 5'h00; fieldWidth <= 6'h01;
    repeat (24) begin
      c = sbx_op_t'($urandom % 16);
      if (c inside {SBX_OP_ZERO_TEST, SBX_OP_NONZERO_TEST, SBX_OP_ARRAY_CHECK}) c = SBX_OP_ASR;
      firstOperand <= $urandom; sourceOperand <= $urandom;
      go(c, 5'h01, base());
    end
    monM = 1'b1;
    go(SBX_OP_MONITOR_CLEAR, 5'h10, base());
    idle("misc");
    check({lastCmd_r, cmdCount_r}, {cpv[22:0], 8'h01});
    bytecodeEntryOk <= 1'b1; sourceOperand <= 32'h0000_6000; firstOperand <= 32'h0000_6000;
    isaM = SBX_ISA_BYTECODE; e = base(); e.xb = 1'b1;
    go(SBX_OP_BYTECODE_BRANCH, 5'h10, e);
    idle("bytecode");
    check(expQ.size(), 0);
    close_out();
  end
endmodule : shift_bitfield_branch_exec_tb
